/* shared/adcdg_pkg.sv */
// Purpose: Shared constants and types for the ADC diagnostic command block
// Assumes: 10 MHz mclk, Avalon-MM register access, 16-bit result words
// Notes: All offsets are byte addresses of 32-bit aligned words
package adcdg_pkg;
  // Clock rate in kHz
  localparam int CLK_KHZ = 10000;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STATB = 8'h08;
  localparam logic [7:0] OFS_DIAGIN = 8'h0c;
  localparam logic [7:0] OFS_CELL = 8'h40;
  localparam logic [7:0] OFS_AUX = 8'h80;
  localparam logic [7:0] OFS_STATR = 8'hc0;
  // Result array sizes
  localparam int NCELL = 15;
  localparam int NAUX = 12;
  localparam int NSTAT = 4;
  // Aux slot of second reference (group B, first word after GPIO3)
  localparam int AUX_REF = 3;
  // Aux group D last four words are flags, untouched by aux clear
  localparam int AUX_KEEP = 8;
  // Aux words filled by the aux self-test: nine GPIO and the reference
  localparam int NAUX_ST = 10;
  // Cell slot indices used by overlap command
  localparam int CELL7 = 6;
  localparam int CELL8 = 7;
  localparam int CELL13 = 12;
  localparam int CELL14 = 13;
  // Command codes in CMD[3:0]
  localparam logic [3:0] C_NONE = 4'h0;
  localparam logic [3:0] C_CELL = 4'h1;
  localparam logic [3:0] C_OVL = 4'h2;
  localparam logic [3:0] C_AUX = 4'h3;
  localparam logic [3:0] C_MUX = 4'h4;
  localparam logic [3:0] C_CST = 4'h5;
  localparam logic [3:0] C_AST = 4'h6;
  localparam logic [3:0] C_SST = 4'h7;
  localparam logic [3:0] C_CLRC = 4'h8;
  localparam logic [3:0] C_CLRA = 4'h9;
  localparam logic [3:0] C_CLRS = 4'ha;
  localparam logic [3:0] C_OPEN = 4'hb;
  localparam logic [3:0] C_STB = 4'hc;
  // Command field positions
  localparam int F_MODE = 4;
  localparam int F_ST = 8;
  localparam int F_PUP = 10;
  // Conversion mode codes
  localparam logic [2:0] M27K = 3'h0;
  localparam logic [2:0] M14K = 3'h1;
  // Self-test patterns
  localparam logic [15:0] P1_27 = 16'h9565;
  localparam logic [15:0] P1_14 = 16'h9553;
  localparam logic [15:0] P1_SL = 16'h9555;
  localparam logic [15:0] P2_27 = 16'h6a9a;
  localparam logic [15:0] P2_14 = 16'h6aac;
  localparam logic [15:0] P2_SL = 16'h6aaa;
  localparam logic [15:0] CLRW = 16'hffff;
  // Overlap command total times in us per mode
  localparam int OVL_US [8] = '{384, 442, 791, 1024, 1490, 2420, 4282,
                                67119};
  // Cell conversion total times in us per mode
  localparam int CELL_US [8] = '{1147, 1322, 2369, 3067, 4463, 7256,
                                 12842, 201351};
  // Mux check times in us, reference up or from standby; aux and status use cell times
  localparam int MUX_REF_US = 400;
  localparam int MUX_STBY_US = 4500;
  localparam int US_CYC = CLK_KHZ / 1000;
  // Status B bit positions
  localparam int SB_MUX = 0;
  localparam int SB_THERMAL_SHUTDOWN_FLAG = 1;
  localparam int SB_REV = 4;
  localparam logic [3:0] REV_CODE = 4'h3; // Arbitrary value
  // Bus word
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } adcdg_req_s;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BUSY = 2'b01,
    S_DONE = 2'b10
  } adcdg_state_e;
endpackage

/* src/adcdg_top.sv */
// Purpose: ADC diagnostic commands: overlap, reference, mux, self-test,
//   clears and open wire, with result storage and Avalon-MM access
// Assumes: Analog results arrive on diagnostic inputs each conversion
// Notes: Conversion timing is counted, analog values are sampled at end, overlap cells 7 and 8 at the midpoint
`timescale 1ns/100ps
module adcdg_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] adcResultA,
  input wire logic [15:0] adcResultB,
  input wire logic muxDecoderFail,
  input wire logic referencePoweredState,
  input wire logic thermalEvent,
  output logic testStreamSel,
  output logic testStreamBit,
  output logic sourceEnable,
  output logic pullupSelect
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [15:0] resA1_r, resA_r, resB1_r, resB_r; // Analog word sync
  logic [3:0] pin1_r, pin_r; // Fail, ref up, thermal, spare
  // Two flops before use
  always_ff @(posedge mclk) begin
    if (rst) begin
      resA1_r <= 16'h0000;
      resA_r <= 16'h0000;
      resB1_r <= 16'h0000;
      resB_r <= 16'h0000;
      pin1_r <= 4'h0;
      pin_r <= 4'h0;
    end else begin
      resA1_r <= adcResultA;
      resA_r <= resA1_r;
      resB1_r <= adcResultB;
      resB_r <= resB1_r;
      pin1_r <= {1'b0, thermalEvent, referencePoweredState,
                 muxDecoderFail};
      pin_r <= pin1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Bus slave, one wait cycle on each access
  adcdg_pkg::adcdg_req_s req;
  logic ack_r; // Access completes
  logic wrEn, rdEn;
  assign req = '{addr: avs_address, wr: avs_write, rd: avs_read,
                 wdata: avs_writedata};
  // Waitrequest low one cycle after request
  assign avs_waitrequest = (req.wr | req.rd) & ~ack_r;
  assign wrEn = req.wr & ack_r;
  assign rdEn = req.rd & ack_r;
  // Ack toggles per access
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (req.wr | req.rd) & ~ack_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  adcdg_pkg::adcdg_state_e state_r;
  logic [3:0] cmd_r; // Running command
  logic [2:0] mode_r; // Conversion mode
  logic [1:0] stOpt_r; // Selftest option
  logic pup_r; // Pull-up select
  logic [21:0] cnt_r; // Cycle countdown
  logic phase_r; // Overlap second phase
  logic [21:0] endCnt; // Duration of accepted command
  logic [21:0] halfCnt; // Overlap first phase point
  logic [3:0] newCmd;
  logic start, fin, mux_fault_flag_r;
  logic [15:0] pattern;
  assign newCmd = req.wdata[3:0];
  assign start = wrEn && req.addr == adcdg_pkg::OFS_CMD &&
                 state_r != adcdg_pkg::S_BUSY;
  assign fin = state_r == adcdg_pkg::S_BUSY && cnt_r == 22'd1;
  // Duration lookup per command and mode
  always_comb begin
    endCnt = 22'd1;
    case (newCmd)
      adcdg_pkg::C_OVL: endCnt = 22'(adcdg_pkg::OVL_US[req.wdata[6:4]] *
                         adcdg_pkg::US_CYC);
      adcdg_pkg::C_CELL, adcdg_pkg::C_OPEN, adcdg_pkg::C_AUX,
      adcdg_pkg::C_CST, adcdg_pkg::C_AST, adcdg_pkg::C_SST:
        endCnt = 22'(adcdg_pkg::CELL_US[req.wdata[6:4]] *
                 adcdg_pkg::US_CYC);
      adcdg_pkg::C_MUX: endCnt = pin_r[1] ?
        22'(adcdg_pkg::MUX_REF_US * adcdg_pkg::US_CYC) :
        22'(adcdg_pkg::MUX_STBY_US * adcdg_pkg::US_CYC);
      default: endCnt = 22'd1;
    endcase
  end
  assign halfCnt = 22'(adcdg_pkg::OVL_US[mode_r] * adcdg_pkg::US_CYC / 2);
  // State and countdown
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= adcdg_pkg::S_IDLE;
      cmd_r <= adcdg_pkg::C_NONE;
      mode_r <= 3'h0;
      stOpt_r <= 2'h0;
      pup_r <= 1'b0;
      cnt_r <= 22'd0;
      phase_r <= 1'b0;
    end else if (start) begin
      state_r <= adcdg_pkg::S_BUSY;
      cmd_r <= newCmd;
      mode_r <= req.wdata[6:4];
      stOpt_r <= req.wdata[9:8];
      pup_r <= req.wdata[adcdg_pkg::F_PUP];
      cnt_r <= endCnt;
      phase_r <= 1'b0;
    end else if (state_r == adcdg_pkg::S_BUSY) begin
      cnt_r <= cnt_r - 22'd1;
      // Cells 7 and 8 first, then cells 13 and 14
      if (cnt_r == halfCnt) begin
        phase_r <= 1'b1;
      end
      if (fin) begin
        state_r <= adcdg_pkg::S_DONE;
      end
    end
  end
  // Self-test stream steering, filtered path replaced by test bit
  assign testStreamSel = state_r == adcdg_pkg::S_BUSY &&
    (cmd_r == adcdg_pkg::C_CST || cmd_r == adcdg_pkg::C_AST ||
     cmd_r == adcdg_pkg::C_SST);
  assign testStreamBit = testStreamSel & (stOpt_r[0] ^ cnt_r[0]);
  // Open wire current sources on during conversion
  assign sourceEnable = state_r == adcdg_pkg::S_BUSY &&
                        cmd_r == adcdg_pkg::C_OPEN;
  assign pullupSelect = pup_r;
  // Filtered pattern for selftest option and mode
  always_comb begin
    pattern = adcdg_pkg::CLRW;
    if (stOpt_r == 2'b01) begin
      pattern = mode_r == adcdg_pkg::M27K ? adcdg_pkg::P1_27 :
        mode_r == adcdg_pkg::M14K ? adcdg_pkg::P1_14 :
        adcdg_pkg::P1_SL;
    end else if (stOpt_r == 2'b10) begin
      pattern = mode_r == adcdg_pkg::M27K ? adcdg_pkg::P2_27 :
        mode_r == adcdg_pkg::M14K ? adcdg_pkg::P2_14 :
        adcdg_pkg::P2_SL;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Result storage
  logic [15:0] cell_r [adcdg_pkg::NCELL]; // Cell words
  logic [15:0] aux_r [adcdg_pkg::NAUX]; // Aux words, D tail holds flags
  logic [15:0] stat_r [adcdg_pkg::NSTAT]; // Sum, temp, supplies
  logic [3:0] ovlIdx;
  assign ovlIdx = 4'(phase_r ? adcdg_pkg::CELL13 : adcdg_pkg::CELL7);
  // Cell results; overlap writes two slots per phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < adcdg_pkg::NCELL; i++) cell_r[i] <= 16'hffff;
    end else if (start && newCmd == adcdg_pkg::C_CLRC) begin
      for (int i = 0; i < adcdg_pkg::NCELL; i++)
        cell_r[i] <= adcdg_pkg::CLRW;
    end else if (state_r == adcdg_pkg::S_BUSY && cmd_r == adcdg_pkg::C_OVL
                 && (cnt_r == halfCnt || fin)) begin
      cell_r[ovlIdx] <= resB_r;
      cell_r[ovlIdx + 4'd1] <= resA_r;
    end else if (fin && cmd_r == adcdg_pkg::C_CST) begin
      for (int i = 0; i < adcdg_pkg::NCELL; i++)
        cell_r[i] <= pattern;
    end else if (fin && (cmd_r == adcdg_pkg::C_CELL ||
                 cmd_r == adcdg_pkg::C_OPEN)) begin
      for (int i = 0; i < adcdg_pkg::NCELL; i++)
        cell_r[i] <= resA_r;
    end
  end
  // Aux results; second reference at group B slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < adcdg_pkg::NAUX; i++) aux_r[i] <= 16'hffff;
    end else if (start && newCmd == adcdg_pkg::C_CLRA) begin
      for (int i = 0; i < adcdg_pkg::AUX_KEEP; i++)
        aux_r[i] <= adcdg_pkg::CLRW;
    end else if (start && newCmd == adcdg_pkg::C_CLRS) begin
      for (int i = adcdg_pkg::AUX_KEEP; i < adcdg_pkg::NAUX; i++)
        aux_r[i] <= adcdg_pkg::CLRW;
    end else if (fin && cmd_r == adcdg_pkg::C_AST) begin
      // All GPIO words and the reference, spilling into group D
      for (int i = 0; i < adcdg_pkg::NAUX_ST; i++)
        aux_r[i] <= pattern;
    end else if (fin && cmd_r == adcdg_pkg::C_AUX) begin
      for (int i = 0; i < adcdg_pkg::AUX_KEEP; i++)
        aux_r[i] <= resA_r;
      aux_r[adcdg_pkg::AUX_REF] <= resB_r;
    end
  end
  // Status results
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < adcdg_pkg::NSTAT; i++) stat_r[i] <= 16'hffff;
    end else if (start && newCmd == adcdg_pkg::C_CLRS) begin
      for (int i = 0; i < adcdg_pkg::NSTAT; i++)
        stat_r[i] <= adcdg_pkg::CLRW;
    end else if (fin && cmd_r == adcdg_pkg::C_SST) begin
      for (int i = 0; i < adcdg_pkg::NSTAT; i++)
        stat_r[i] <= pattern;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Status B flags
  logic thermal_shutdown_flag_r; // Thermal shutdown flag
  logic statBRead;
  assign statBRead = rdEn && req.addr == adcdg_pkg::OFS_STATB;
  // Mux fault flag, one at reset and status clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      mux_fault_flag_r <= 1'b1;
    end else if (start && newCmd == adcdg_pkg::C_CLRS) begin
      mux_fault_flag_r <= 1'b1;
    end else if (start && newCmd == adcdg_pkg::C_MUX) begin
      // Cleared once at acceptance, so a long standby run keeps any fail
      mux_fault_flag_r <= 1'b0;
    end else if (state_r == adcdg_pkg::S_BUSY &&
                 cmd_r == adcdg_pkg::C_MUX && pin_r[0]) begin
      // Any failing decoder sets it for the rest of the run
      mux_fault_flag_r <= 1'b1;
    end
  end
  // Thermal flag: event or clear sets, read clears, set wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      thermal_shutdown_flag_r <= 1'b0;
    end else if (pin_r[2] || (start && newCmd == adcdg_pkg::C_CLRS)) begin
      thermal_shutdown_flag_r <= 1'b1;
    end else if (statBRead) begin
      thermal_shutdown_flag_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Read mux, reserved bits zero
  logic [31:0] rdMux;
  logic [5:0] idx;
  assign idx = req.addr[7:2] & 6'h0f;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (req.addr == adcdg_pkg::OFS_STATUS) begin
      rdMux = {30'h0, state_r};
    end else if (req.addr == adcdg_pkg::OFS_STATB) begin
      rdMux = {24'h0, adcdg_pkg::REV_CODE, 2'b00, thermal_shutdown_flag_r,
               mux_fault_flag_r};
    end else if (req.addr == adcdg_pkg::OFS_CMD) begin
      rdMux = {21'h0, pup_r, stOpt_r, 1'b0, mode_r, cmd_r};
    end else if (req.addr[7:6] == 2'b01 && idx < 6'(adcdg_pkg::NCELL)) begin
      rdMux = {16'h0, cell_r[idx[3:0]]};
    end else if (req.addr[7:6] == 2'b10 && idx < 6'(adcdg_pkg::NAUX)) begin
      rdMux = {16'h0, aux_r[idx[3:0]]};
    end else if (req.addr[7:6] == 2'b11 && idx < 6'(adcdg_pkg::NSTAT)) begin
      rdMux = {16'h0, stat_r[idx[1:0]]};
    end
  end
  // Registered read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req.rd & ~ack_r) begin
      avs_readdata <= rdMux;
    end
  end
endmodule // adcdg_top

/* dv/adcdg_checker.sv */
// Purpose: Port-level assertions for adcdg_top
// Assumes: Commands are only written while the block is idle
// Notes: Durations get two cycles of slack for the state hand-off
`timescale 1ns/100ps
module adcdg_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic testStreamSel,
  input wire logic sourceEnable,
  input wire logic pullupSelect
);
  //////////////////////////////////////////////////////////////////////////
  logic cmdAcc; // Command word accepted
  logic stCmd; // Accepted word is a self-test
  logic [2:0] modeR; // Mode of last command
  logic pupR; // Pull-up bit of last command
  logic [21:0] stCnt; // Cycles of test stream so far
  logic [21:0] owCnt; // Cycles of current sources so far
  int dur; // Expected conversion length
  assign cmdAcc = avs_write && !avs_waitrequest
    && avs_address == adcdg_pkg::OFS_CMD;
  assign stCmd = avs_writedata[3:0] >= adcdg_pkg::C_CST
    && avs_writedata[3:0] <= adcdg_pkg::C_SST;
  assign dur = adcdg_pkg::CELL_US[modeR] * adcdg_pkg::US_CYC;
  // Latch fields; clears also land here but start nothing
  always_ff @(posedge mclk) begin
    if (rst) begin
      modeR <= 3'h0;
      pupR <= 1'b0;
    end else if (cmdAcc) begin
      modeR <= avs_writedata[6:4];
      pupR <= avs_writedata[10];
    end
  end
  // Length counters, cleared on the first edge that samples the output low
  always_ff @(posedge mclk) begin
    if (rst) begin
      stCnt <= 22'h0;
      owCnt <= 22'h0;
    end else begin
      stCnt <= testStreamSel ? stCnt + 22'h1 : 22'h0;
      owCnt <= sourceEnable ? owCnt + 22'h1 : 22'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  wait_phase_a: assert property ($rose(avs_read) || $rose(avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait phase");
  one_source_a: assert property (!(testStreamSel && sourceEnable))
    else $error("stream and sources together");
  st_start_a: assert property (cmdAcc && stCmd |-> ##[1:3] testStreamSel)
    else $error("self-test stream missing");
  st_len_a: assert property ($fell(testStreamSel)
    |-> stCnt >= dur - 2 && stCnt <= dur + 2) else $error("self-test length");
  ow_start_a: assert property (cmdAcc
    && avs_writedata[3:0] == adcdg_pkg::C_OPEN |-> ##[1:3] sourceEnable)
    else $error("current sources missing");
  ow_len_a: assert property ($fell(sourceEnable)
    |-> owCnt >= dur - 2 && owCnt <= dur + 2) else $error("open-wire length");
  pup_match_a: assert property (sourceEnable |-> pullupSelect == pupR)
    else $error("pull direction wrong");
  statb_rev_a: assert property (avs_read && !avs_waitrequest
    && avs_address == adcdg_pkg::OFS_STATB |-> avs_readdata[31:8] == 24'h0
    && avs_readdata[7:4] == adcdg_pkg::REV_CODE && avs_readdata[3:2] == 2'h0)
    else $error("status B fixed bits");
  unmapped_a: assert property (avs_read && !avs_waitrequest
    && avs_address == 8'hfc |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  st_seen_c: cover property ($fell(testStreamSel));
  ow_up_c: cover property (sourceEnable && pullupSelect);
  ow_down_c: cover property (sourceEnable && !pullupSelect);
endmodule // adcdg_checker
bind adcdg_top adcdg_checker u_chk (.mclk(mclk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .testStreamSel(testStreamSel),
  .sourceEnable(sourceEnable), .pullupSelect(pullupSelect));

/* dv/adcdg_analog_model.sv */
// Purpose: Analog front end behind the diagnostic block
// Assumes: Every cell reads the same voltage
// Notes: Open-wire current moves the primary reading by one step
`timescale 1ns/100ps
module adcdg_analog_model #(
  parameter logic [15:0] CELL_V = 16'h9c40,
  parameter logic [15:0] REF_V = 16'h7544,
  parameter logic [15:0] OW_STEP = 16'h0100
) (
  input wire logic sourceEnable,
  input wire logic pullupSelect,
  output logic [15:0] adcResultA,
  output logic [15:0] adcResultB
);
  // Sourcing lifts the pin, sinking drags it down
  always_comb begin
    if (!sourceEnable) begin
      adcResultA = CELL_V;
    end else if (pullupSelect) begin
      adcResultA = CELL_V + OW_STEP;
    end else begin
      adcResultA = CELL_V - OW_STEP;
    end
  end
  // Partner converter and second reference share this output
  assign adcResultB = REF_V;
endmodule // adcdg_analog_model

/* dv/testbench.sv */
// Purpose: Register-level regression for adcdg_top
// Assumes: Fastest modes keep the run short
// Notes: Durations are measured by status polling
`timescale 1ns/100ps
module testbench;
  logic mclk;
  logic rst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] adcResultA;
  logic [15:0] adcResultB;
  logic muxDecoderFail;
  logic referencePoweredState;
  logic thermalEvent;
  logic testStreamSel;
  logic sourceEnable;
  logic pullupSelect;
  logic [31:0] rd; // Last read data
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0; // Clock cycles since start
  //////////////////////////////////////////////////////////////////////////
  adcdg_top u_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adcResultA(adcResultA),
    .adcResultB(adcResultB), .muxDecoderFail(muxDecoderFail),
    .referencePoweredState(referencePoweredState),
    .thermalEvent(thermalEvent), .testStreamSel(testStreamSel),
    .testStreamBit(), .sourceEnable(sourceEnable),
    .pullupSelect(pullupSelect));
  adcdg_analog_model u_model (.sourceEnable(sourceEnable),
    .pullupSelect(pullupSelect), .adcResultA(adcResultA),
    .adcResultB(adcResultB));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic busRd(input logic [7:0] a);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    busRd(a);
    chk($sformatf("reg %h", a), rd, exp);
  endtask
  // Starts a command and checks its busy time against t cycles
  task automatic run(input logic [3:0] c, input logic [2:0] m,
                     input logic [1:0] s, input logic p, input int t);
    int t0;
    busWr(adcdg_pkg::OFS_CMD, {21'h0, p, s, 1'b0, m, c});
    t0 = cyc;
    do busRd(adcdg_pkg::OFS_STATUS); while (rd !== 32'h2);
    chk("duration", 32'(cyc - t0 >= t - 2 && cyc - t0 <= t + 8), 32'h1);
  endtask
  task automatic rdRange(input logic [7:0] b, input int n, input int k,
                         input logic [15:0] v);
    for (int i = k; i < n; i++) rdChk(b + 8'(4 * i), {16'h0, v});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int cc;
    cc = adcdg_pkg::CELL_US[0] * adcdg_pkg::US_CYC;
    rst = 1'b1;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    muxDecoderFail = 1'b0;
    referencePoweredState = 1'b1;
    thermalEvent = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rdChk(adcdg_pkg::OFS_STATB, {24'h0, adcdg_pkg::REV_CODE, 4'h1});
    rdChk(8'hfc, 32'h0);
    thermalEvent <= 1'b1;
    repeat (4) @(posedge mclk);
    thermalEvent <= 1'b0;
    repeat (4) @(posedge mclk);
    rdChk(adcdg_pkg::OFS_STATB, {24'h0, adcdg_pkg::REV_CODE, 4'h3});
    rdChk(adcdg_pkg::OFS_STATB, {24'h0, adcdg_pkg::REV_CODE, 4'h1});
    // Overlap: partner reading lands in the lower slot of each pair
    run(adcdg_pkg::C_OVL, adcdg_pkg::M27K, 2'h0, 1'b0,
        adcdg_pkg::OVL_US[0] * adcdg_pkg::US_CYC);
    rdRange(adcdg_pkg::OFS_CELL, 7, 6, adcResultB);
    rdRange(adcdg_pkg::OFS_CELL, 8, 7, adcResultA);
    rdRange(adcdg_pkg::OFS_CELL, 13, 12, adcResultB);
    rdRange(adcdg_pkg::OFS_CELL, 14, 13, adcResultA);
    run(adcdg_pkg::C_AUX, adcdg_pkg::M27K, 2'h0, 1'b0, cc);
    rdRange(adcdg_pkg::OFS_AUX, 4, 3, adcResultB);
    chk("ref window", 32'(rd >= 32'h74cc && rd <= 32'h75bc), 32'h1);
    // Mux check, passing and then failing decoders
    for (int f = 0; f < 2; f++) begin
      muxDecoderFail <= f[0];
      run(adcdg_pkg::C_MUX, adcdg_pkg::M27K, 2'h0, 1'b0,
          adcdg_pkg::MUX_REF_US * adcdg_pkg::US_CYC);
      rdChk(adcdg_pkg::OFS_STATB,
            {24'h0, adcdg_pkg::REV_CODE, 3'h0, f[0]});
    end
    run(adcdg_pkg::C_SST, adcdg_pkg::M27K, 2'h2, 1'b0, cc);
    rdRange(adcdg_pkg::OFS_STATR, 4, 0, adcdg_pkg::P2_27);
    busWr(adcdg_pkg::OFS_CMD, {28'h0, adcdg_pkg::C_CLRS});
    rdChk(adcdg_pkg::OFS_STATB, {24'h0, adcdg_pkg::REV_CODE, 4'h3});
    rdRange(adcdg_pkg::OFS_STATR, 4, 0, adcdg_pkg::CLRW);
    run(adcdg_pkg::C_CST, adcdg_pkg::M27K, 2'h1, 1'b0, cc);
    rdRange(adcdg_pkg::OFS_CELL, 15, 0, adcdg_pkg::P1_27);
    busWr(adcdg_pkg::OFS_CMD, {28'h0, adcdg_pkg::C_CLRC});
    rdRange(adcdg_pkg::OFS_CELL, 15, 0, adcdg_pkg::CLRW);
    run(adcdg_pkg::C_AST, adcdg_pkg::M14K, 2'h2, 1'b0,
        adcdg_pkg::CELL_US[1] * adcdg_pkg::US_CYC);
    rdRange(adcdg_pkg::OFS_AUX, 10, 0, adcdg_pkg::P2_14);
    busWr(adcdg_pkg::OFS_CMD, {28'h0, adcdg_pkg::C_CLRA});
    rdRange(adcdg_pkg::OFS_AUX, 8, 0, adcdg_pkg::CLRW);
    rdRange(adcdg_pkg::OFS_AUX, 10, 8, adcdg_pkg::P2_14);
    // Open wire, sourcing then sinking; one run each keeps the bench short
    run(adcdg_pkg::C_OPEN, adcdg_pkg::M27K, 2'h0, 1'b1, cc);
    rdRange(adcdg_pkg::OFS_CELL, 15, 0, 16'h9d40);
    run(adcdg_pkg::C_OPEN, adcdg_pkg::M27K, 2'h0, 1'b0, cc);
    rdRange(adcdg_pkg::OFS_CELL, 15, 0, 16'h9b40);
    chk("top wire", 32'(rd[15:0] != 16'h0), 32'h1);
    summarize();
  end
endmodule // testbench
